/* File: include/tal_regs.svh */
/*
 Constants of the temperature alarm, relay and analog output block.
 Assumes readings in 0.1 K steps and sensor units in 10 uV or 1 mOhm.
*/
`ifndef TAL_REGS_SVH
`define TAL_REGS_SVH
// Notes on behaviour
// - High alarm when kelvin reading exceeds high setpoint or is off curve top.
// - Low alarm when kelvin reading is below low setpoint or off curve bottom.
// - Setpoints held in kelvin, compared with the kelvin reading only.
// - Both alarms stay inactive while no curve is assigned.
// - Active alarm flashes display between reading and high or low indicator.
// - Latched alarm stays asserted after its cause goes, until cleared.
// - Cancel key press clears every latched alarm.
// - Non-latched high alarm releases at high setpoint minus deadband.
// - Alarm enable off stops evaluation and refuses setpoint, deadband, latch.
// - High setpoint accepted from 0 to 999.9 K.
// - Low setpoint has the same range and resolution as the high one.
// - Deadband accepted from 0 to 99.9 K.
// - Latch setting is one bit, 0 off and 1 on.
// - Relay one follows low alarm, relay two follows high alarm.
// - Relay one is off, on, or follows the low alarm.
// - Relay two is off, on, or follows the high alarm.
// - Range low end gives output zero level, 0 V or 4 mA.
// - Range high end gives full output, linear in between.
// - Voltage or current mode; ranges 0..5 span 20 to 1000 K.
// - Without curve, output spans sensor units fixed by input type.
// - With curve, output always follows the kelvin reading.
// - Output step at most 15 ppm of full scale.

// ==========================================
// Widths
`define TAL_K_W 16
`define TAL_VAL_W 24
`define TAL_CODE_W 20
`define TAL_NUM_W 44

// ==========================================
// Setting limits and reset values, 0.1 K steps
`define TAL_SP_MAX 16'h270F
`define TAL_DB_MAX 16'h03E7
`define TAL_SP_RST 16'h0000
`define TAL_DB_RST 16'h0000
`define TAL_RANGE_MAX 3'h5
`define TAL_RANGE_RST 3'h5

// ==========================================
// Full scales: ranges in 0.1 K, sensors in 10 uV or 1 mOhm
`define TAL_FS_RNG0 24'h0000C8
`define TAL_FS_RNG1 24'h0003E8
`define TAL_FS_RNG2 24'h0007D0
`define TAL_FS_RNG3 24'h000CB2
`define TAL_FS_RNG4 24'h00128E
`define TAL_FS_RNG5 24'h002710
`define TAL_FS_DIODE 24'h0F4240
`define TAL_FS_PT 24'h0F4240
`define TAL_FS_NTC 24'h989680

// ==========================================
// Timing
`define TAL_CLK_HZ 10000000
`define TAL_FLASH_MS 500
`endif

/* File: include/tal_pkg.sv */
/*
 Types of the temperature alarm block.
 Assumes tal_regs.svh is on the include path.
*/
`include "tal_regs.svh"
package tal_pkg;
   typedef enum logic [1:0] {TAL_RLY_OFF, TAL_RLY_ON, TAL_RLY_FOLLOW} tal_relay_mode_t;
   typedef enum logic [2:0] {
      TAL_IN_SI, TAL_IN_GAAS, TAL_IN_PT250, TAL_IN_PT500, TAL_IN_PT1K, TAL_IN_NTC
   } tal_in_type_t;
   typedef enum logic [3:0] {
      TAL_SET_EN, TAL_SET_HI, TAL_SET_LO, TAL_SET_DB, TAL_SET_LATCH,
      TAL_SET_R1, TAL_SET_R2, TAL_SET_AMODE, TAL_SET_ARANGE
   } tal_set_sel_t;
   typedef enum logic [1:0] {TAL_IND_NONE, TAL_IND_HIGH, TAL_IND_LOW} tal_ind_t;

   typedef struct packed {
      logic valid;
      logic [`TAL_K_W-1:0] kelvin;
      logic [`TAL_VAL_W-1:0] sensor;
      logic curve_ok;
      logic off_hi;
      logic off_lo;
   } tal_sample_t;

   typedef struct packed {
      logic wr;
      tal_set_sel_t sel;
      logic [`TAL_K_W-1:0] val;
   } tal_setting_t;

   typedef struct packed {
      logic valid;
      logic current;
      logic [`TAL_CODE_W-1:0] code;
   } tal_aout_t;

   typedef struct packed {
      logic busy;
      logic done;
      logic [5:0] cnt;
      logic [`TAL_NUM_W-1:0] num;
      logic [`TAL_VAL_W:0] rem;
      logic [`TAL_VAL_W-1:0] den;
      logic [`TAL_CODE_W-1:0] code;
   } tal_scale_state_t;

   typedef struct packed {
      logic en;
      logic [`TAL_K_W-1:0] hi_sp;
      logic [`TAL_K_W-1:0] lo_sp;
      logic [`TAL_K_W-1:0] db;
      logic latch;
      tal_relay_mode_t r1;
      tal_relay_mode_t r2;
      logic current;
      logic [2:0] range;
      logic curve_ok;
      logic alarm_hi;
      logic alarm_lo;
      logic relay1;
      logic relay2;
      logic refused;
      logic flash;
      logic [22:0] flash_cnt;
   } tal_state_t;
endpackage

/* File: verilog/tal_scale.sv */
/*
 Serial divider that maps a value onto the output code: code = v*max/fs.
 Assumes fs is never zero; a start while busy is ignored.
*/
`timescale 1ns/1ps
`include "tal_regs.svh"
module tal_scale (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Request
   input wire logic start_i,
   input wire logic [`TAL_VAL_W-1:0] value_i,
   input wire logic [`TAL_VAL_W-1:0] fs_i,
   // Result
   output logic busy_o,
   output logic done_o,
   output logic [`TAL_CODE_W-1:0] code_o
);
   import tal_pkg::*;
   localparam int NW = `TAL_NUM_W;
   localparam logic [NW-1:0] CODE_MAX = NW'((64'd1 << `TAL_CODE_W) - 64'd1);

   tal_scale_state_t st_r, st_nxt;
   logic [`TAL_VAL_W-1:0] vclamp;
   logic [`TAL_VAL_W:0] rem_sh;

   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      vclamp = (value_i > fs_i) ? fs_i : value_i;
      rem_sh = {st_r.rem[`TAL_VAL_W-1:0], st_r.num[NW-1]};
      if (!st_r.busy) begin
         if (start_i) begin
            st_nxt.num = NW'(vclamp) * CODE_MAX;
            st_nxt.den = fs_i;
            st_nxt.rem = '0;
            st_nxt.cnt = 6'(NW);
            st_nxt.busy = 1'b1;
         end
      end else begin
         if (rem_sh >= {1'b0, st_r.den}) begin
            st_nxt.rem = rem_sh - {1'b0, st_r.den};
            st_nxt.num = {st_r.num[NW-2:0], 1'b1};
         end else begin
            st_nxt.rem = rem_sh;
            st_nxt.num = {st_r.num[NW-2:0], 1'b0};
         end
         st_nxt.cnt = st_r.cnt - 6'h01;
         if (st_r.cnt == 6'h01) begin
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
            st_nxt.code = st_nxt.num[`TAL_CODE_W-1:0];
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign busy_o = st_r.busy;
   assign done_o = st_r.done;
   assign code_o = st_r.code;

   property p_full_scale;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (start_i && !st_r.busy && value_i >= fs_i) |-> ##45 (done_o && code_o == '1);
   endproperty
   a_full_scale: assert property (p_full_scale) else $error("full scale code wrong");

   property p_zero;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (start_i && !st_r.busy && value_i == '0) |-> ##45 (done_o && code_o == '0);
   endproperty
   a_zero: assert property (p_zero) else $error("zero code wrong");
endmodule // tal_scale

/* File: verilog/tal_alarm_top.sv */
/*
 Alarm, relay and analog output logic of a temperature monitor.
 Assumes samples and settings arrive synchronous to clk_sys_i,
 each as a one-cycle strobe; sensor conversion happens upstream.
*/
`timescale 1ns/1ps
`include "tal_regs.svh"
module tal_alarm_top #(
   parameter int FLASH_CYC = `TAL_FLASH_MS * (`TAL_CLK_HZ / 1000)
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Reading from the conversion stage
   input wire tal_pkg::tal_sample_t sample_i,
   input wire tal_pkg::tal_in_type_t in_type_i,
   // Front-panel settings
   input wire tal_pkg::tal_setting_t setting_i,
   input wire logic cancel_i,
   output logic set_refused_o,
   output logic alarm_en_o,
   // Alarms and display
   output logic alarm_hi_o,
   output logic alarm_lo_o,
   output logic disp_flash_o,
   output tal_pkg::tal_ind_t disp_ind_o,
   // Relays
   output logic relay1_o,
   output logic relay2_o,
   // Analog output
   output tal_pkg::tal_aout_t aout_o
);
   import tal_pkg::*;

   // ==========================================
   // Local signals
   tal_state_t st_r, st_nxt;
   logic [`TAL_K_W-1:0] kel;
   logic eval;
   logic hi_trip, hi_rel, lo_trip, lo_rel;
   logic [`TAL_K_W:0] hi_rel_sum, lo_rel_sum;
   logic bad;
   logic [`TAL_VAL_W-1:0] sc_val, sc_fs;
   logic sc_busy, sc_done;
   logic [`TAL_CODE_W-1:0] sc_code;

   assign kel = sample_i.kelvin;

   // ==========================================
   // Alarm conditions
   // kelvin compare only
   assign hi_rel_sum = {1'b0, kel} + {1'b0, st_r.db};
   assign lo_rel_sum = {1'b0, st_r.lo_sp} + {1'b0, st_r.db};
   assign hi_trip = sample_i.off_hi || (kel > st_r.hi_sp);
   assign hi_rel = !sample_i.off_hi && (hi_rel_sum <= {1'b0, st_r.hi_sp});
   assign lo_trip = sample_i.off_lo || (kel < st_r.lo_sp);
   assign lo_rel = !sample_i.off_lo && ({1'b0, kel} >= lo_rel_sum);
   // evaluate only with curve and enable
   assign eval = sample_i.valid && sample_i.curve_ok && st_r.en;

   // ==========================================
   // Setting checks
   always_comb begin
      bad = 1'b0;
      unique case (setting_i.sel)
         TAL_SET_EN: bad = 1'b0;
         TAL_SET_HI, TAL_SET_LO: bad = setting_i.val > `TAL_SP_MAX;
         TAL_SET_DB: bad = setting_i.val > `TAL_DB_MAX;
         TAL_SET_LATCH: bad = setting_i.val > 16'h0001;
         TAL_SET_R1, TAL_SET_R2: bad = setting_i.val > 16'h0002;
         TAL_SET_AMODE: bad = setting_i.val > 16'h0001;
         TAL_SET_ARANGE: bad = setting_i.val > 16'(`TAL_RANGE_MAX);
         default: bad = 1'b1;
      endcase
      if (!st_r.en && (setting_i.sel inside {TAL_SET_HI, TAL_SET_LO, TAL_SET_DB,
            TAL_SET_LATCH})) begin
         bad = 1'b1;
      end
   end

   // ==========================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.refused = 1'b0;
      if (setting_i.wr) begin
         if (bad) begin
            st_nxt.refused = 1'b1;
         end else begin
            unique case (setting_i.sel)
               TAL_SET_EN: st_nxt.en = setting_i.val[0];
               TAL_SET_HI: st_nxt.hi_sp = setting_i.val;
               TAL_SET_LO: st_nxt.lo_sp = setting_i.val;
               TAL_SET_DB: st_nxt.db = setting_i.val;
               TAL_SET_LATCH: st_nxt.latch = setting_i.val[0];
               TAL_SET_R1: st_nxt.r1 = tal_relay_mode_t'(setting_i.val[1:0]);
               TAL_SET_R2: st_nxt.r2 = tal_relay_mode_t'(setting_i.val[1:0]);
               TAL_SET_AMODE: st_nxt.current = setting_i.val[0];
               TAL_SET_ARANGE: st_nxt.range = setting_i.val[2:0];
               default: st_nxt.refused = 1'b1;
            endcase
         end
      end
      if (sample_i.valid) begin
         st_nxt.curve_ok = sample_i.curve_ok;
      end

      // High alarm; a trip in the cancel cycle wins
      if (eval && hi_trip) begin
         st_nxt.alarm_hi = 1'b1;
      end else if (st_r.latch) begin
         if (cancel_i) begin
            st_nxt.alarm_hi = 1'b0;
         end
      end else if (eval && hi_rel) begin
         st_nxt.alarm_hi = 1'b0;
      end

      // Low alarm, mirrored
      if (eval && lo_trip) begin
         st_nxt.alarm_lo = 1'b1;
      end else if (st_r.latch) begin
         if (cancel_i) begin
            st_nxt.alarm_lo = 1'b0;
         end
      end else if (eval && lo_rel) begin
         st_nxt.alarm_lo = 1'b0;
      end

      if (!st_r.en || (sample_i.valid && !sample_i.curve_ok)
            || (!sample_i.valid && !st_r.curve_ok)) begin
         st_nxt.alarm_hi = 1'b0;
         st_nxt.alarm_lo = 1'b0;
      end

      unique case (st_r.r1)
         TAL_RLY_OFF: st_nxt.relay1 = 1'b0;
         TAL_RLY_ON: st_nxt.relay1 = 1'b1;
         TAL_RLY_FOLLOW: st_nxt.relay1 = st_r.alarm_lo;
         default: st_nxt.relay1 = 1'b0;
      endcase
      unique case (st_r.r2)
         TAL_RLY_OFF: st_nxt.relay2 = 1'b0;
         TAL_RLY_ON: st_nxt.relay2 = 1'b1;
         TAL_RLY_FOLLOW: st_nxt.relay2 = st_r.alarm_hi;
         default: st_nxt.relay2 = 1'b0;
      endcase

      // flash timer, phase restarts when no alarm is active
      if (st_r.alarm_hi || st_r.alarm_lo) begin
         if (st_r.flash_cnt >= 23'(FLASH_CYC - 1)) begin
            st_nxt.flash_cnt = '0;
            st_nxt.flash = !st_r.flash;
         end else begin
            st_nxt.flash_cnt = st_r.flash_cnt + 23'h000001;
         end
      end else begin
         st_nxt.flash_cnt = '0;
         st_nxt.flash = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_r <= '0;
         st_r.hi_sp <= `TAL_SP_RST;
         st_r.lo_sp <= `TAL_SP_RST;
         st_r.db <= `TAL_DB_RST;
         st_r.range <= `TAL_RANGE_RST;
         st_r.r1 <= TAL_RLY_OFF;
         st_r.r2 <= TAL_RLY_OFF;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================
   // Analog output scaling
   always_comb begin
      sc_fs = `TAL_FS_RNG5;
      sc_val = sample_i.sensor;
      if (sample_i.curve_ok) begin
         sc_val = `TAL_VAL_W'(kel);
         unique case (st_r.range)
            3'h0: sc_fs = `TAL_FS_RNG0;
            3'h1: sc_fs = `TAL_FS_RNG1;
            3'h2: sc_fs = `TAL_FS_RNG2;
            3'h3: sc_fs = `TAL_FS_RNG3;
            3'h4: sc_fs = `TAL_FS_RNG4;
            default: sc_fs = `TAL_FS_RNG5;
         endcase
      end else begin
         unique case (in_type_i)
            TAL_IN_SI, TAL_IN_GAAS: sc_fs = `TAL_FS_DIODE;
            TAL_IN_PT250, TAL_IN_PT500: sc_fs = `TAL_FS_PT;
            default: sc_fs = `TAL_FS_NTC;
         endcase
      end
   end

   // A sample that arrives while busy is dropped; the next one refreshes
   // 20-bit code, about 1 ppm step
   tal_scale u_scale (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .start_i(sample_i.valid),
      .value_i(sc_val),
      .fs_i(sc_fs),
      .busy_o(sc_busy),
      .done_o(sc_done),
      .code_o(sc_code)
   );

   // ==========================================
   // Outputs
   assign aout_o.valid = sc_done;
   assign aout_o.current = st_r.current;
   assign aout_o.code = sc_code;
   assign alarm_hi_o = st_r.alarm_hi;
   assign alarm_lo_o = st_r.alarm_lo;
   assign relay1_o = st_r.relay1;
   assign relay2_o = st_r.relay2;
   assign set_refused_o = st_r.refused;
   assign alarm_en_o = st_r.en;
   assign disp_flash_o = st_r.flash;
   // high takes precedence when both are active
   assign disp_ind_o = !st_r.flash ? TAL_IND_NONE :
                       st_r.alarm_hi ? TAL_IND_HIGH : TAL_IND_LOW;

   // ==========================================
   // Checks
   property p_hi_trip;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (eval && kel > st_r.hi_sp) |=> alarm_hi_o;
   endproperty
   a_hi_trip: assert property (p_hi_trip) else $error("high alarm missed");

   property p_lo_trip;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (eval && sample_i.off_lo) |=> alarm_lo_o;
   endproperty
   a_lo_trip: assert property (p_lo_trip) else $error("low alarm missed");

   property p_no_curve;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      // A fresh sample with a curve may legally trip again, so only a gap counts
      (sample_i.valid && !sample_i.curve_ok) ##1 !sample_i.valid
         |-> (!alarm_hi_o && !alarm_lo_o) ##1 (!alarm_hi_o && !alarm_lo_o);
   endproperty
   a_no_curve: assert property (p_no_curve) else $error("alarm without curve");

   property p_latch_hold;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (st_r.latch && alarm_hi_o && st_r.en && !cancel_i && st_r.curve_ok
         && !(sample_i.valid && !sample_i.curve_ok)) |=> alarm_hi_o;
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latch lost");

   property p_cancel;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (st_r.latch && cancel_i && !sample_i.valid) |=> (!alarm_hi_o && !alarm_lo_o);
   endproperty
   a_cancel: assert property (p_cancel) else $error("cancel ignored");

   property p_hyst;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!st_r.latch && alarm_hi_o && eval && !hi_trip
         && hi_rel_sum > {1'b0, st_r.hi_sp}) |=> alarm_hi_o;
   endproperty
   a_hyst: assert property (p_hyst) else $error("early high release");

   property p_disabled;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      !alarm_en_o |=> (!alarm_hi_o && !alarm_lo_o);
   endproperty
   a_disabled: assert property (p_disabled) else $error("alarm while disabled");

   property p_sp_range;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (setting_i.wr && setting_i.sel == TAL_SET_HI && setting_i.val > `TAL_SP_MAX)
         |=> (set_refused_o && $stable(st_r.hi_sp));
   endproperty
   a_sp_range: assert property (p_sp_range) else $error("setpoint not refused");

   property p_db_range;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (setting_i.wr && setting_i.sel == TAL_SET_DB && setting_i.val > `TAL_DB_MAX)
         |=> set_refused_o;
   endproperty
   a_db_range: assert property (p_db_range) else $error("deadband not refused");

   property p_relay1;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (st_r.r1 == TAL_RLY_FOLLOW) |=> (relay1_o == $past(alarm_lo_o));
   endproperty
   a_relay1: assert property (p_relay1) else $error("relay one not following");

   property p_relay2;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (st_r.r2 == TAL_RLY_FOLLOW) |=> (relay2_o == $past(alarm_hi_o));
   endproperty
   a_relay2: assert property (p_relay2) else $error("relay two not following");

   property p_flash;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!alarm_hi_o && !alarm_lo_o) |=> (disp_ind_o == TAL_IND_NONE);
   endproperty
   a_flash: assert property (p_flash) else $error("indicator without alarm");
endmodule // tal_alarm_top

/* File: testbench/tal_recorder.sv */
/*
 Recorder model at the far side of the analog output.
 Assumes aout valid pulses are synchronous to clk_sys_i.
*/
`timescale 1ns/1ps
module tal_recorder (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // Analog output
   input wire tal_pkg::tal_aout_t aout_i,
   // Logged point
   output logic stb_o,
   output tal_pkg::tal_aout_t point_o
);
   import tal_pkg::*;
   // ==========================================
   // Capture
   // Only settled points are logged, never the output between updates
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stb_o <= 1'b0;
         point_o <= '0;
      end else begin
         stb_o <= aout_i.valid;
         if (aout_i.valid)
            point_o <= aout_i;
      end
   end
endmodule // tal_recorder

/* File: testbench/tal_alarm_top_tb_top.sv */
/*
 Self-checking bench of the alarm, relay and analog output block.
 Assumes tal_pkg is compiled first and tal_regs.svh is on the include path.
*/
`timescale 1ns/1ps
`include "tal_regs.svh"
module tal_alarm_top_tb_top;
   import tal_pkg::*;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   tal_sample_t sample_i = '0;
   tal_in_type_t in_type_i = TAL_IN_SI;
   tal_setting_t setting_i = '0;
   logic cancel_i = 1'b0;
   logic set_refused_o, alarm_en_o, alarm_hi_o, alarm_lo_o, disp_flash_o;
   logic relay1_o, relay2_o, rec_stb, flash_seen;
   tal_ind_t disp_ind_o;
   tal_aout_t aout_o, rec_point, exp_pt;
   tal_aout_t exp_q[$];
   int failures = 0;
   int n_checks = 0;
   logic [2:0] cur_rng = 3'h5;
   logic cur_mode = 1'b0;
   int unsigned rng_fs[6] = '{32'h00C8, 32'h03E8, 32'h07D0, 32'h0CB2, 32'h128E, 32'h2710};

   always #50 clk_sys_i = ~clk_sys_i;

   tal_alarm_top #(.FLASH_CYC(8)) i_dut (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sample_i(sample_i),
      .in_type_i(in_type_i), .setting_i(setting_i), .cancel_i(cancel_i),
      .set_refused_o(set_refused_o), .alarm_en_o(alarm_en_o), .alarm_hi_o(alarm_hi_o),
      .alarm_lo_o(alarm_lo_o), .disp_flash_o(disp_flash_o), .disp_ind_o(disp_ind_o),
      .relay1_o(relay1_o), .relay2_o(relay2_o), .aout_o(aout_o)
   );
   tal_recorder i_rec (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .aout_i(aout_o),
      .stb_o(rec_stb), .point_o(rec_point)
   );

   // ==========================================
   // Shared tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic close_out;
      if (failures == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic set(input tal_set_sel_t sel, input logic [15:0] val, input logic refuse);
      setting_i <= '{wr: 1'b1, sel: sel, val: val};
      @(negedge clk_sys_i);
      setting_i.wr <= 1'b0;
      chk("set_refused", 32'(refuse), 32'(set_refused_o));
      if (!refuse && sel == TAL_SET_ARANGE)
         cur_rng = val[2:0];
      if (!refuse && sel == TAL_SET_AMODE)
         cur_mode = val[0];
      // Let an edge pass so the next call never re-raises wr in this step
      @(negedge clk_sys_i);
      chk("set_refused_end", 0, 32'(set_refused_o));
   endtask

   // f is {curve, off high, off low}; e is {high, low, relay 1, relay 2}
   task automatic samp(input logic [15:0] k, input logic [23:0] s, input logic [2:0] f,
                       input logic [3:0] e);
      int unsigned fs;
      longint unsigned v;
      fs = f[2] ? rng_fs[cur_rng] : (in_type_i < TAL_IN_PT1K ? 32'h000F4240 : 32'h00989680);
      v = f[2] ? 64'(k) : 64'(s);
      if (v > fs)
         v = fs;
      exp_q.push_back('{valid: 1'b1, current: cur_mode, code: 20'(v * 64'hFFFFF / fs)});
      sample_i <= '{valid: 1'b1, kelvin: k, sensor: s, curve_ok: f[2], off_hi: f[1],
                    off_lo: f[0]};
      @(negedge clk_sys_i);
      sample_i.valid <= 1'b0;
      chk("alarm_hi", 32'(e[3]), 32'(alarm_hi_o));
      chk("alarm_lo", 32'(e[2]), 32'(alarm_lo_o));
      @(negedge clk_sys_i);
      chk("relay1", 32'(e[1]), 32'(relay1_o));
      chk("relay2", 32'(e[0]), 32'(relay2_o));
      // Divider must be idle again, busy samples would be dropped
      repeat (46) @(negedge clk_sys_i);
   endtask

   task automatic flash_chk(input tal_ind_t ind);
      flash_seen = 1'b0;
      repeat (24) begin
         @(negedge clk_sys_i);
         if (disp_flash_o === 1'b1)
            flash_seen = 1'b1;
         chk("disp_ind", 32'(disp_flash_o ? ind : TAL_IND_NONE), 32'(disp_ind_o));
      end
      chk("flash_seen", 1, 32'(flash_seen));
   endtask

   // ==========================================
   // Output watcher
   always @(negedge clk_sys_i) begin
      if (rec_stb === 1'b1) begin
         exp_pt = exp_q.size() > 0 ? exp_q.pop_front() : '0;
         chk("aout_code", 32'(exp_pt.code), 32'(rec_point.code));
         chk("aout_current", 32'(exp_pt.current), 32'(rec_point.current));
      end
   end

   // ==========================================
   // Main sequence
   initial begin
      int unused;
      unused = $urandom(32'h045B);
      repeat (8) @(negedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(negedge clk_sys_i);
      chk("alarm_en_rst", 0, 32'(alarm_en_o));
      chk("relays_rst", 0, 32'({relay1_o, relay2_o}));
      set(TAL_SET_HI, 16'h0064, 1'b1);
      set(TAL_SET_EN, 16'h0001, 1'b0);
      chk("alarm_en", 1, 32'(alarm_en_o));
      set(TAL_SET_HI, 16'h2710, 1'b1);
      set(TAL_SET_HI, 16'h270F, 1'b0);
      set(TAL_SET_LO, 16'h2710, 1'b1);
      set(TAL_SET_DB, 16'h03E8, 1'b1);
      set(TAL_SET_DB, 16'h03E7, 1'b0);
      set(TAL_SET_DB, 16'h000A, 1'b0);
      set(TAL_SET_LATCH, 16'h0002, 1'b1);
      set(TAL_SET_ARANGE, 16'h0006, 1'b1);
      set(TAL_SET_R1, 16'h0003, 1'b1);
      set(TAL_SET_HI, 16'h03E8, 1'b0);
      set(TAL_SET_LO, 16'h01F4, 1'b0);
      set(TAL_SET_R1, 16'h0002, 1'b0);
      set(TAL_SET_R2, 16'h0002, 1'b0);
      samp(16'h03E8, 24'h0, 3'b100, 4'h0);
      samp(16'h03E9, 24'h0, 3'b100, 4'h9);
      flash_chk(TAL_IND_HIGH);
      samp(16'h03E3, 24'h0, 3'b100, 4'h9);
      samp(16'h03DE, 24'h0, 3'b100, 4'h0);
      samp(16'h01F3, 24'h0, 3'b100, 4'h6);
      flash_chk(TAL_IND_LOW);
      samp(16'h01F9, 24'h0, 3'b100, 4'h6);
      samp(16'h01FE, 24'h0, 3'b100, 4'h0);
      samp(16'h02BC, 24'h0, 3'b110, 4'h9);
      samp(16'h02BC, 24'h0, 3'b101, 4'h6);
      samp(16'h02BC, 24'h0, 3'b100, 4'h0);
      samp(16'h2000, 24'($urandom_range(32'h00A00000)), 3'b000, 4'h0);
      set(TAL_SET_LATCH, 16'h0001, 1'b0);
      samp(16'h03E9, 24'h0, 3'b100, 4'h9);
      samp(16'h02BC, 24'h0, 3'b100, 4'h9);
      cancel_i <= 1'b1;
      @(negedge clk_sys_i);
      cancel_i <= 1'b0;
      chk("alarm_hi_cancel", 0, 32'(alarm_hi_o));
      @(negedge clk_sys_i);
      chk("relay2_cancel", 0, 32'(relay2_o));
      set(TAL_SET_LATCH, 16'h0000, 1'b0);
      set(TAL_SET_R1, 16'h0001, 1'b0);
      set(TAL_SET_R2, 16'h0000, 1'b0);
      samp(16'h03E9, 24'h0, 3'b100, 4'hA);
      samp(16'h03DE, 24'h0, 3'b100, 4'h2);
      set(TAL_SET_R1, 16'h0000, 1'b0);
      set(TAL_SET_EN, 16'h0000, 1'b0);
      samp(16'h03E9, 24'h0, 3'b100, 4'h0);
      set(TAL_SET_LATCH, 16'h0000, 1'b1);
      set(TAL_SET_AMODE, 16'h0002, 1'b1);
      set(TAL_SET_AMODE, 16'h0001, 1'b0);
      for (int r = 0; r < 6; r++) begin
         set(TAL_SET_ARANGE, 16'(r), 1'b0);
         samp(16'h0000, 24'h0, 3'b100, 4'h0);
         samp(16'($urandom_range(rng_fs[r])), 24'h0, 3'b100, 4'h0);
         samp(16'(rng_fs[r]), 24'h0, 3'b100, 4'h0);
         samp(16'(rng_fs[r] + 32'h0011), 24'h0, 3'b100, 4'h0);
      end
      set(TAL_SET_AMODE, 16'h0000, 1'b0);
      for (int t = 0; t < 6; t++) begin
         in_type_i = tal_in_type_t'(t);
         samp(16'h0000, 24'($urandom_range(32'h00A00000)), 3'b000, 4'h0);
      end
      samp(16'h1388, 24'h000123, 3'b100, 4'h0);
      repeat (50) @(negedge clk_sys_i);
      chk("aout_pending", 0, 32'(exp_q.size()));
      close_out();
   end

   // Sequence needs about 2400 cycles; the limit leaves a wide margin
   initial begin
      #(10000 * 100);
      failures++;
      close_out();
   end
endmodule // tal_alarm_top_tb_top
